// *** src/upw_regs.svh ***
// Register map, field positions, reset values and timing constants
// Operation
// R01: Definite-time delay only for trip and reset
// R02: ON and OFF events per start, trip, blocked
// R03: Setting selects which events are stored
// R04: Keep last twelve records, written on ON
// R05: Record holds time, event, powers, remaining, group
// R06: Eight setting groups, one active at once
// R07: Instant mode issues start and trip together
// R08: Event timestamps have one millisecond resolution
// R09: Clearable counters of start, trip, blocked
// R10: Input is three-phase power every 5 ms
// R11: Pre-fault record uses 20 ms average
// R12: Force status overrides state in test mode
// R13: General settings independent of setting group
// R14: Release level fixed at 103 % of threshold
// R15: Low-power inhibit holds until power exceeds 1.03x
// R16: Threshold and inhibit level in 0.01 kW steps
// R17: Start only when pickup and not blocked
// R18: Read-only condition, times and power ratio
// R19: Blocking input sampled every processing cycle
// R20: Block at pickup gives blocked, clears start
// R21: Blocking raises notification and power event
// R22: Blocking source leads delay by 5 ms
// R23: Power below threshold is the pickup condition
`ifndef UPW_REGS_SVH
`define UPW_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define UPW_A_CTRL 8'h00
`define UPW_A_STAT 8'h04
`define UPW_A_OPTIME 8'h08
`define UPW_A_REMAIN 8'h0c
`define UPW_A_RATIO 8'h10
`define UPW_A_CNT_ST 8'h14
`define UPW_A_CNT_TR 8'h18
`define UPW_A_CNT_BK 8'h1c
`define UPW_A_RSEL 8'h20
`define UPW_A_R_TS 8'h24
`define UPW_A_R_EVT 8'h28
`define UPW_A_R_PRE 8'h2c
`define UPW_A_R_FLT 8'h30
`define UPW_A_R_PF 8'h34
`define UPW_A_R_REM 8'h38
`define UPW_A_R_SG 8'h3c
`define UPW_A_RELDLY 8'h40
`define UPW_G_BIT 7
`define UPW_G_THR 4'h0
`define UPW_G_LPL 4'h4
`define UPW_G_DLY 4'h8

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define UPW_C_ON 0
`define UPW_C_OFF 1
`define UPW_C_FRC 2
`define UPW_C_CLR 4

// ----------------------------------------------------------------
// Sizes, reset values, timing
// ----------------------------------------------------------------
`define UPW_REC_N 4'hc
`define UPW_HIST_N 10
`define UPW_DLY_MAX 19'h57e40
`define UPW_THR_RST 24'h002710
`define UPW_LPL_RST 24'h001388
`define UPW_HYS_NUM 32'h00000067
`define UPW_HYS_DEN 32'h00000064
`define UPW_RATIO_MAX 17'h1e848
`define UPW_MS_NS 32'h000f4240
`define UPW_CLK_NS 32'h00000019
`define UPW_DIV_STEPS 5'h1f

`endif

// *** src/upw_pkg.sv ***
// Types shared by the underpower stage and its record memory
package upw_pkg;
`include "upw_regs.svh"

    typedef enum logic [1:0] {
        UPW_NORMAL, UPW_START, UPW_TRIP, UPW_BLOCKED
    } upw_cond_e;

    typedef struct packed {
        logic valid;
        logic [2:0] code;
        logic [31:0] ts;
        logic [23:0] pwr;
    } upw_evt_s;

    typedef struct packed {
        logic [31:0] ts;
        logic [1:0] evt;
        logic [23:0] pre;
        logic [23:0] flt;
        logic [23:0] pf;
        logic [18:0] rem;
        logic [2:0] grp;
    } upw_rec_s;

    typedef struct packed {
        upw_rec_s [11:0] mem;
        upw_rec_s rd;
    } upw_mem_s;

    typedef struct packed {
        upw_cond_e cond;
        logic pick;
        logic low_power_inhibit;
        logic [18:0] tmr;
        logic [18:0] rel;
        logic [2:0] outs;
        logic [5:0] evp;
        logic [2:0] rcp;
        logic hmi;
        upw_evt_s evt;
        logic [15:0] ms_div;
        logic [31:0] ts;
        logic [31:0] ev_ts;
        logic [23:0] ev_pwr;
        upw_rec_s snap;
        logic [3:0][23:0] samp;
        logic [1:0] qcnt;
        logic [9:0][23:0] hist;
        logic [3:0] wptr;
        logic [3:0] nrec;
        logic ev_on;
        logic ev_off;
        logic [1:0] frc;
        logic [18:0] rel_dly;
        logic [7:0][23:0] pickup_threshold;
        logic [7:0][23:0] low_power_level;
        logic [7:0][18:0] definite_delay;
        logic [2:0][15:0] cnt;
        logic [3:0] rsel;
        logic [31:0] rdata;
        logic [30:0] dnum;
        logic [23:0] drem;
        logic [30:0] quot;
        logic [4:0] dcnt;
        logic [16:0] ratio;
    } upw_st_s;
endpackage

// *** src/upw_rec_mem.sv ***
// Twelve-entry operation record memory with registered read
`timescale 1ns/10ps
`include "upw_regs.svh"
module upw_rec_mem import upw_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Write side
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input upw_rec_s wr_data,
    // Read side
    input wire logic [3:0] rd_addr,
    output upw_rec_s rd_data
);
    upw_mem_s m_q;
    upw_mem_s m_d;

    always_comb begin
        m_d = m_q;
        if (wr_en && wr_addr < `UPW_REC_N) begin
            m_d.mem[wr_addr] = wr_data;
        end
        m_d.rd = (rd_addr < `UPW_REC_N) ? m_q.mem[rd_addr] : '0;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            m_q <= '0;
        end else begin
            m_q <= m_d;
        end
    end

    assign rd_data = m_q.rd;
endmodule // upw_rec_mem

// *** src/upw_stage.sv ***
// Underpower protection stage with events, records and counters
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "upw_regs.svh"
module upw_stage import upw_pkg::*; #(
    parameter int MS_CYCLES = `UPW_MS_NS / `UPW_CLK_NS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Measurement and control inputs
    input wire logic pwr_valid,
    input wire logic [23:0] measured_power,
    input wire logic block_in,
    input wire logic force_en,
    input wire logic [2:0] setting_group,
    // Stage outputs
    output logic stage_start,
    output logic stage_trip,
    output logic stage_blocked,
    output logic hmi_notify,
    output upw_evt_s evt,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    upw_st_s s_q;
    upw_st_s s_d;
    upw_rec_s rec_rd;
    upw_rec_s rec_wd;
    logic rec_we;

    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    // ----------------------------------------------------------------
    // Record memory
    // ----------------------------------------------------------------
    upw_rec_mem u_mem (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .wr_en(rec_we),
        .wr_addr(s_q.wptr),
        .wr_data(rec_wd),
        .rd_addr(s_q.rsel),
        .rd_data(rec_rd)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [23:0] thr;
        logic [23:0] lpl;
        logic [18:0] dly;
        logic [31:0] pw100;
        logic [31:0] th103;
        logic lo;
        logic hi;
        logic pk;
        logic lp;
        logic eff;
        logic hit;
        upw_cond_e fcond;
        logic [2:0] outs;
        logic [2:0] on;
        logic [2:0] off;
        logic [25:0] sum;
        logic [24:0] r;
        logic [2:0] gi;
        thr = s_q.pickup_threshold[setting_group];
        lpl = s_q.low_power_level[setting_group];
        dly = s_q.definite_delay[setting_group];
        pw100 = '0;
        th103 = '0;
        lo = 1'b0;
        hi = 1'b0;
        pk = 1'b0;
        lp = 1'b0;
        eff = 1'b0;
        hit = 1'b0;
        fcond = UPW_NORMAL;
        outs = '0;
        on = '0;
        off = '0;
        sum = 26'(s_q.samp[0]) + 26'(s_q.samp[1])
            + 26'(s_q.samp[2]) + 26'(s_q.samp[3]);
        r = '0;
        gi = reg_addr[6:4];
        rec_we = 1'b0;
        rec_wd = s_q.snap;
        s_d = s_q;
        s_d.evt.valid = 1'b0;
        s_d.hmi = 1'b0;
        s_d.rdata = '0;

        // Millisecond time base
        if (s_q.ms_div >= MS_LAST) begin
            s_d.ms_div = '0;
            s_d.ts = s_q.ts + 32'h1; // R08
        end else begin
            s_d.ms_div = s_q.ms_div + 16'h1;
        end

        // Ratio divider, one quotient bit per clock
        if (s_q.dcnt != 5'h0) begin
            r = {s_q.drem, s_q.dnum[30]};
            s_d.dnum = {s_q.dnum[29:0], 1'b0};
            if (r >= 25'(thr)) begin
                s_d.drem = 24'(r - 25'(thr));
                s_d.quot = {s_q.quot[29:0], 1'b1};
            end else begin
                s_d.drem = r[23:0];
                s_d.quot = {s_q.quot[29:0], 1'b0};
            end
            s_d.dcnt = s_q.dcnt - 5'h1;
        end else if (s_q.quot > 31'(`UPW_RATIO_MAX)) begin
            s_d.ratio = `UPW_RATIO_MAX; // R18
        end else begin
            s_d.ratio = s_q.quot[16:0];
        end

        // Drain pending events one per clock, lowest code first
        for (int i = 0; i < 6; i++) begin
            if (s_q.evp[i] && !hit) begin
                hit = 1'b1;
                s_d.evp[i] = 1'b0;
                s_d.evt.valid = 1'b1; // R02
                s_d.evt.code = 3'(i);
                s_d.evt.ts = s_q.ev_ts;
                s_d.evt.pwr = s_q.ev_pwr; // R21
            end
        end
        hit = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (s_q.rcp[i] && !hit) begin
                hit = 1'b1;
                s_d.rcp[i] = 1'b0;
                rec_we = 1'b1; // R04
                rec_wd.evt = 2'(i);
            end
        end
        if (hit) begin
            s_d.wptr = (s_q.wptr >= `UPW_REC_N - 4'h1) ?
                4'h0 : s_q.wptr + 4'h1;
            if (s_q.nrec < `UPW_REC_N) begin
                s_d.nrec = s_q.nrec + 4'h1;
            end
        end

        // Register writes
        if (reg_wr) begin
            if (reg_addr == `UPW_A_CTRL) begin
                s_d.ev_on = reg_wdata[`UPW_C_ON]; // R03
                s_d.ev_off = reg_wdata[`UPW_C_OFF];
                s_d.frc = reg_wdata[`UPW_C_FRC +: 2]; // R12
                if (reg_wdata[`UPW_C_CLR]) begin
                    s_d.cnt = '0; // R09
                end
            end else if (reg_addr == `UPW_A_RSEL) begin
                s_d.rsel = reg_wdata[3:0];
            end else if (reg_addr == `UPW_A_RELDLY) begin
                s_d.rel_dly = (reg_wdata[18:0] > `UPW_DLY_MAX) ?
                    `UPW_DLY_MAX : reg_wdata[18:0]; // R13
            end else if (reg_addr[`UPW_G_BIT]) begin
                case (reg_addr[3:0])
                    `UPW_G_THR: begin
                        s_d.pickup_threshold[gi] =
                            (reg_wdata[23:0] == 24'h0) ?
                            24'h1 : reg_wdata[23:0]; // R16
                    end
                    `UPW_G_LPL: begin
                        s_d.low_power_level[gi] =
                            (reg_wdata[23:0] == 24'h0) ?
                            24'h1 : reg_wdata[23:0]; // R16
                    end
                    `UPW_G_DLY: begin
                        s_d.definite_delay[gi] =
                            (reg_wdata[18:0] > `UPW_DLY_MAX) ?
                            `UPW_DLY_MAX : reg_wdata[18:0]; // R06
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Processing cycle on each new power sample
        if (pwr_valid) begin // R10
            pw100 = 32'(measured_power) * `UPW_HYS_DEN;
            th103 = 32'(thr) * `UPW_HYS_NUM;
            lo = measured_power < thr; // R23
            hi = pw100 > th103; // R14
            pk = lo ? 1'b1 : (hi ? 1'b0 : s_q.pick);
            lp = hi ? 1'b0 :
                ((measured_power < lpl) ? 1'b1 : s_q.low_power_inhibit); // R15
            eff = pk && !lp;
            s_d.pick = pk;
            s_d.low_power_inhibit = lp;
            if (eff && block_in) begin // R19
                s_d.cond = UPW_BLOCKED; // R20
                s_d.tmr = '0;
                s_d.rel = '0;
            end else if (eff) begin // R17
                s_d.rel = '0;
                case (s_q.cond)
                    UPW_START: begin
                        if (s_q.tmr <= 19'h1) begin
                            s_d.cond = UPW_TRIP; // R01
                            s_d.tmr = '0;
                        end else begin
                            s_d.tmr = s_q.tmr - 19'h1;
                        end
                    end
                    UPW_TRIP: begin
                    end
                    default: begin
                        if (dly == 19'h0) begin
                            s_d.cond = UPW_TRIP; // R07
                        end else begin
                            s_d.cond = UPW_START;
                            s_d.tmr = dly;
                        end
                    end
                endcase
            end else begin
                case (s_q.cond)
                    UPW_START, UPW_TRIP: begin
                        if (s_q.rel >= s_q.rel_dly) begin
                            s_d.cond = UPW_NORMAL; // R01
                            s_d.tmr = '0;
                            s_d.rel = '0;
                        end else begin
                            s_d.rel = s_q.rel + 19'h1;
                        end
                    end
                    default: begin
                        s_d.cond = UPW_NORMAL;
                    end
                endcase
            end

            // Forcing replaces the state only while test mode is on
            fcond = force_en ? upw_cond_e'(s_q.frc) : s_d.cond; // R12
            outs[0] = fcond == UPW_START || fcond == UPW_TRIP;
            outs[1] = fcond == UPW_TRIP;
            outs[2] = fcond == UPW_BLOCKED;
            on = outs & ~s_q.outs;
            off = ~outs & s_q.outs;
            s_d.outs = outs;
            for (int i = 0; i < 3; i++) begin
                s_d.evp[2*i] = s_d.evp[2*i] | (on[i] & s_q.ev_on);
                s_d.evp[2*i+1] = s_d.evp[2*i+1]
                    | (off[i] & s_q.ev_off); // R03
                s_d.cnt[i] = s_d.cnt[i] + 16'(on[i]); // R09
            end
            s_d.rcp = s_d.rcp | on; // R04
            s_d.hmi = on[2]; // R21
            if (on != 3'h0 || off != 3'h0) begin
                s_d.ev_ts = s_q.ts; // R07
                s_d.ev_pwr = measured_power;
            end
            if (on != 3'h0) begin
                s_d.snap.ts = s_q.ts; // R05
                s_d.snap.pre = sum[25:2]; // R11
                s_d.snap.flt = measured_power;
                s_d.snap.pf = s_q.hist[`UPW_HIST_N-1];
                s_d.snap.rem = s_d.tmr;
                s_d.snap.grp = setting_group;
            end

            // History: four-sample averages, pushed every 20 ms
            s_d.samp = {s_q.samp[2:0], measured_power};
            s_d.qcnt = s_q.qcnt + 2'h1;
            if (s_q.qcnt == 2'h3) begin
                s_d.hist = {s_q.hist[`UPW_HIST_N-2:0], sum[25:2]};
            end

            // Ratio restarts with each sample, done well inside 5 ms
            s_d.dnum = 31'(pw100);
            s_d.drem = '0;
            s_d.quot = '0;
            s_d.dcnt = `UPW_DIV_STEPS;
        end

        // Register reads, answered in the next cycle
        if (reg_rd) begin
            case (reg_addr)
                `UPW_A_CTRL: s_d.rdata = 32'({s_q.frc, s_q.ev_off,
                    s_q.ev_on});
                `UPW_A_STAT: s_d.rdata = 32'({s_q.nrec, s_q.pick,
                    s_q.low_power_inhibit, s_q.cond}); // R18
                `UPW_A_OPTIME: s_d.rdata = 32'(dly);
                `UPW_A_REMAIN: s_d.rdata = (s_q.cond == UPW_START) ?
                    32'(s_q.tmr) : 32'h0;
                `UPW_A_RATIO: s_d.rdata = 32'(s_q.ratio);
                `UPW_A_CNT_ST: s_d.rdata = 32'(s_q.cnt[0]);
                `UPW_A_CNT_TR: s_d.rdata = 32'(s_q.cnt[1]);
                `UPW_A_CNT_BK: s_d.rdata = 32'(s_q.cnt[2]);
                `UPW_A_RSEL: s_d.rdata = 32'(s_q.rsel);
                `UPW_A_R_TS: s_d.rdata = rec_rd.ts;
                `UPW_A_R_EVT: s_d.rdata = 32'(rec_rd.evt);
                `UPW_A_R_PRE: s_d.rdata = 32'(rec_rd.pre);
                `UPW_A_R_FLT: s_d.rdata = 32'(rec_rd.flt);
                `UPW_A_R_PF: s_d.rdata = 32'(rec_rd.pf);
                `UPW_A_R_REM: s_d.rdata = 32'(rec_rd.rem);
                `UPW_A_R_SG: s_d.rdata = 32'(rec_rd.grp);
                `UPW_A_RELDLY: s_d.rdata = 32'(s_q.rel_dly);
                default: begin
                    if (reg_addr[`UPW_G_BIT]) begin
                        case (reg_addr[3:0])
                            `UPW_G_THR: s_d.rdata =
                                32'(s_q.pickup_threshold[gi]);
                            `UPW_G_LPL: s_d.rdata =
                                32'(s_q.low_power_level[gi]);
                            `UPW_G_DLY: s_d.rdata =
                                32'(s_q.definite_delay[gi]);
                            default: s_d.rdata = '0;
                        endcase
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.low_power_inhibit <= 1'b1;
            s_q.ev_on <= 1'b1;
            s_q.ev_off <= 1'b1;
            s_q.pickup_threshold <= {8{`UPW_THR_RST}};
            s_q.low_power_level <= {8{`UPW_LPL_RST}};
        end else begin
            s_q <= s_d;
        end
    end

    assign stage_start = s_q.outs[0];
    assign stage_trip = s_q.outs[1];
    assign stage_blocked = s_q.outs[2];
    assign hmi_notify = s_q.hmi;
    assign evt = s_q.evt;
    assign reg_rdata = s_q.rdata;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_pickup_below: assert property (pwr_valid && // R23
        measured_power < s_q.pickup_threshold[setting_group]
        |=> s_q.pick)
        else $error("pickup not set below threshold");

    a_hyst_release: assert property (pwr_valid && // R14
        32'(measured_power) * `UPW_HYS_DEN >
        32'(s_q.pickup_threshold[setting_group]) * `UPW_HYS_NUM
        |=> !s_q.pick && !s_q.low_power_inhibit)
        else $error("pickup or inhibit held above release level");

    a_lpb_hold: assert property (s_q.low_power_inhibit && pwr_valid && // R15
        32'(measured_power) * `UPW_HYS_DEN <=
        32'(s_q.pickup_threshold[setting_group]) * `UPW_HYS_NUM
        |=> s_q.low_power_inhibit)
        else $error("inhibit dropped below release level");

    a_block_wins: assert property (pwr_valid && !force_en && // R20
        block_in && !s_q.low_power_inhibit &&
        measured_power >= s_q.low_power_level[setting_group] &&
        measured_power < s_q.pickup_threshold[setting_group]
        |=> stage_blocked && !stage_start && !stage_trip)
        else $error("blocking at pickup did not block");

    a_start_gate: assert property ($rose(stage_start) && // R17
        !$past(force_en) |-> !$past(block_in) && $past(pwr_valid))
        else $error("start rose while blocked");

    a_instant_trip: assert property (pwr_valid && !force_en && // R07
        !block_in && s_q.cond == UPW_NORMAL && !s_q.low_power_inhibit &&
        s_q.definite_delay[setting_group] == 19'h0 &&
        measured_power >= s_q.low_power_level[setting_group] &&
        measured_power < s_q.pickup_threshold[setting_group]
        |=> stage_start && stage_trip ##1 s_q.ev_ts == $past(s_q.ts, 2))
        else $error("instant mode did not trip at once");

    a_force_trip: assert property (pwr_valid && force_en && // R12
        s_q.frc == 2'h2 |=> stage_trip && stage_start && !stage_blocked)
        else $error("forced trip not shown");

    a_trip_event: assert property ($rose(stage_trip) && $past(s_q.ev_on) // R02
        |-> ##[1:6] (evt.valid && evt.code == 3'h2))
        else $error("trip ON event missing");

    a_off_masked: assert property (evt.valid && evt.code[0] // R03
        |-> $past(s_q.ev_off, 2) || $past(s_q.ev_off, 3) ||
        $past(s_q.ev_off, 4) || $past(s_q.ev_off, 5) ||
        $past(s_q.ev_off, 6) || $past(s_q.ev_off, 7))
        else $error("OFF event sent while masked");

    a_trip_count: assert property ($rose(stage_trip) && // R09
        !$past(reg_wr) |-> s_q.cnt[1] == 16'($past(s_q.cnt[1]) + 16'h1))
        else $error("trip counter did not advance");

    a_block_record: assert property ($rose(stage_blocked) // R04
        |-> ##[0:3] (rec_we && rec_wd.evt == 2'h2))
        else $error("blocked record not written");

    a_ms_step: assert property ($changed(s_q.ts) // R08
        |-> s_q.ts == $past(s_q.ts) + 32'h1 && s_q.ms_div == 16'h0)
        else $error("timestamp step not one millisecond");

    c_instant: cover property (pwr_valid ##1 $rose(stage_trip) &&
        $rose(stage_start));
    c_delayed: cover property ($rose(stage_start) ##[1:300]
        $rose(stage_trip));
    c_blocked: cover property ($rose(stage_blocked) && hmi_notify);
    c_forced: cover property (force_en && stage_trip);
endmodule // upw_stage

// *** verification/upw_src.sv ***
// Power sample and blocking source facing the stage
`timescale 1ns/10ps
module upw_src #(
    parameter int PERIOD = 50
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Values asked for by the bench
    input wire logic [23:0] p_set,
    input wire logic b_set,
    // Toward the stage
    output logic pwr_valid,
    output logic [23:0] measured_power,
    output logic block_in
);
    logic [7:0] cnt_q;
    // Level held well ahead of each sample, so it leads any delay
    assign block_in = b_set;
    // Off the sample cycle the bus shows junk, not the last value
    assign measured_power = pwr_valid ? p_set : ~p_set;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 8'h0;
            pwr_valid <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == 8'(PERIOD - 1)) ? 8'h0 : cnt_q + 8'h1;
            pwr_valid <= (cnt_q == 8'(PERIOD - 1));
        end
    end
endmodule // upw_src

// *** verification/test_underpower_protection_stage.sv ***
// Self-checking bench for the underpower stage
`timescale 1ns/10ps
module test_underpower_protection_stage import upw_pkg::*;;
    logic sys_clk = 1'b0, nrst = 1'b0, force_en = 1'b0, b_v = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [2:0] sg = 3'h0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, t;
    logic [23:0] p_v = 24'h0, measured_power, lo;
    logic pwr_valid, block_in, stage_start, stage_trip;
    logic stage_blocked, hmi_notify;
    upw_evt_s evt, e;
    upw_evt_s ev_q[$];
    int mismatches = 0, num_checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    upw_src u_src (.sys_clk(sys_clk), .nrst(nrst), .p_set(p_v),
        .b_set(b_v), .pwr_valid(pwr_valid),
        .measured_power(measured_power), .block_in(block_in));
    upw_stage #(.MS_CYCLES(10)) u_dut (.sys_clk(sys_clk), .nrst(nrst),
        .pwr_valid(pwr_valid), .measured_power(measured_power),
        .block_in(block_in), .force_en(force_en), .setting_group(sg),
        .stage_start(stage_start), .stage_trip(stage_trip),
        .stage_blocked(stage_blocked), .hmi_notify(hmi_notify),
        .evt(evt), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    always @(negedge sys_clk) begin
        if (evt.valid === 1'b1)
            ev_q.push_back(evt);
    end
    task automatic chk(string n, logic [31:0] s, logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask
    function automatic logic [31:0] ratio_exp(logic [23:0] p,
        logic [23:0] th);
        return (32'(p) * 32'h64) / 32'(th);
    endfunction
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] x);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), reg_rdata & m, x);
    endtask
    // Outputs looked at just after the taking edge: the notify pulse is short
    task automatic step(logic [23:0] p, logic b, logic [3:0] o);
        @(posedge sys_clk);
        p_v <= p;
        b_v <= b;
        do @(posedge sys_clk); while (pwr_valid !== 1'b1);
        #1 chk("outputs", {stage_start, stage_trip, stage_blocked,
            hmi_notify}, o);
        repeat (8) @(posedge sys_clk);
    endtask
    task automatic ev(logic [2:0] c);
        e = ev_q.size() ? ev_q.pop_front() : '0;
        chk("event", {e.valid, e.code}, {1'b1, c});
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        stop_test();
    end
    initial begin
        void'($urandom(85));
        lo = 24'h1389 + 24'($urandom % 32'h1386);
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(8'h00, 32'hff, 32'h3);
        rd(8'h80, '1, 32'h2710);
        rd(8'h84, '1, 32'h1388);
        rd(8'h44, '1, 32'h0);
        $display("reset test done");
        step(24'h283c, 1'b0, 4'h0);
        step(lo, 1'b0, 4'h0);
        rd(8'h04, 32'h4, 32'h4);
        step(24'h283d, 1'b0, 4'h0);
        step(lo, 1'b0, 4'hc);
        ev(3'h0);
        t = e.ts;
        ev(3'h2);
        chk("stamp", e.ts, t);
        repeat (24) @(posedge sys_clk);
        rd(8'h10, '1, ratio_exp(lo, 24'h2710));
        rd(8'h04, 32'hf0, 32'h20);
        rd(8'h18, '1, 32'h1);
        wr(8'h00, 32'h13);
        rd(8'h14, '1, 32'h0);
        step(24'h283d, 1'b0, 4'h0);
        ev(3'h1);
        ev(3'h3);
        wr(8'h20, 32'h1);
        rd(8'h28, '1, 32'h1);
        rd(8'h30, '1, 32'(lo));
        rd(8'h2c, '1, (32'h283c + 32'h283d + 32'(lo)) >> 2);
        $display("pickup test done");
        wr(8'h00, 32'h1);
        step(lo, 1'b1, 4'h3);
        ev(3'h4);
        chk("block power", e.pwr, lo);
        step(24'h283d, 1'b0, 4'h0);
        chk("masked", ev_q.size(), 32'h0);
        $display("block test done");
        wr(8'h00, 32'h3);
        wr(8'h88, 32'h2);
        sg <= 3'h3;
        rd(8'h08, '1, 32'h0);
        sg <= 3'h0;
        rd(8'h08, '1, 32'h2);
        step(lo, 1'b0, 4'h8);
        step(lo, 1'b0, 4'h8);
        step(lo, 1'b0, 4'hc);
        step(24'h283d, 1'b0, 4'h0);
        force_en <= 1'b1;
        wr(8'h00, 32'hb);
        step(24'h283d, 1'b0, 4'hc);
        force_en <= 1'b0;
        step(24'h283d, 1'b0, 4'h0);
        $display("delay and force test done");
        stop_test();
    end
endmodule // test_underpower_protection_stage
